// >>> logic/lpsq_pkg.sv
// Package for the low-power mode and restore sequencer: states, straps, timing.
// Assumes a single 25 MHz core clock.
package lpsq_pkg;

    localparam int unsigned CLK_HZ = 25_000_000;

    // Wake and restore times in their own units, cycle counts derived from them.
    localparam int unsigned RET_WAKE_US = 3_000;
    localparam int unsigned HIB_WAKE_US = 50_000;
    localparam int unsigned SHD_WAKE_US = 1_100_000;
    localparam int unsigned RESTORE_US = 8_000_000;
    localparam longint unsigned RET_WAKE_CYC = longint'(RET_WAKE_US) * CLK_HZ / 1_000_000;
    localparam longint unsigned HIB_WAKE_CYC = longint'(HIB_WAKE_US) * CLK_HZ / 1_000_000;
    localparam longint unsigned SHD_WAKE_CYC = longint'(SHD_WAKE_US) * CLK_HZ / 1_000_000;
    localparam longint unsigned RESTORE_CYC = longint'(RESTORE_US) * CLK_HZ / 1_000_000;

    // Boot-option strap code that requests a factory restore.
    localparam logic [2:0] STRAP_RESTORE = 3'h3;

    // Width of the shared sequencing counter.
    localparam int unsigned CNT_W = 28;
    localparam logic [CNT_W-1:0] CNT_ZERO = 28'h000_0000;
    localparam logic [CNT_W-1:0] CNT_ONE = 28'h000_0001;

    typedef enum logic [2:0] {
        LPSQ_ACTIVE  = 3'b000,
        LPSQ_RETAIN  = 3'b001,
        LPSQ_HIBER   = 3'b011,
        LPSQ_SHUTDN  = 3'b010,
        LPSQ_BOOT    = 3'b110,
        LPSQ_RESTORE = 3'b111
    } lpsq_state_t;

    typedef enum logic [1:0] {
        LPSQ_RST_NONE   = 2'h0,
        LPSQ_RST_PARAMS = 2'h1,
        LPSQ_RST_FULL   = 2'h2
    } lpsq_restore_t;

    // Power and status outputs that travel together.
    typedef struct packed {
        logic core_pwr_on;
        logic rtc_on;
        logic retain_en;
        logic ready;
        logic restoring;
    } lpsq_pwr_t;

endpackage

// >>> logic/lpsq_sync.sv
// Two-flop synchroniser for asynchronous pin inputs.
// Assumes the destination clock is core_clk_i.
`timescale 1ns/1ps
module lpsq_sync #(
    parameter int unsigned WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic clk_en_i,
    // Data
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta_q;

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            meta_q <= RST_VAL;
            sync_o <= RST_VAL;
        end else if (clk_en_i) begin
            meta_q <= async_i;
            sync_o <= meta_q;
        end
    end
endmodule // lpsq_sync

// >>> logic/lpsq_top.sv
// Low-power mode and factory-restore sequencer of the device.
// Assumes host pins are asynchronous and the persistent restore flag is held in
// always-on storage outside this block and fed back through restore_pending_i.
//
// Overview of operation
// RULE_01 - Retention sleep is entered and left autonomously, no host handshake.
// RULE_02 - Leaving retention sleep on timer or host command completes within 3 ms.
// RULE_03 - Retention sleep keeps software state and selected configuration intact.
// RULE_04 - Hibernate gates core logic, keeps always-on section and RTC running.
// RULE_05 - Host asserts hibernate wake request; device starts waking at assertion.
// RULE_06 - Hibernate wake takes about 50 ms; counter covers that span.
// RULE_07 - Shutdown turns everything off, RTC too; waking takes about 1.1 s.
// RULE_08 - Three restore choices: none, defaults only, image plus defaults.
// RULE_09 - Straps at 011 sampled on external reset rising edge start restore.
// RULE_10 - Restore is fail-safe; interrupted restore resumes at next power-up.
// RULE_11 - Factory restore takes about 8 s; no normal operation meanwhile.
// RULE_12 - Host access to the protected factory-image sector is always denied.
// RULE_13 - Exit from hibernate or shutdown runs full boot before host commands.
`timescale 1ns/1ps
module lpsq_top
    import lpsq_pkg::*;
#(
    parameter longint unsigned RET_WAKE_CYCLES = lpsq_pkg::RET_WAKE_CYC,
    parameter longint unsigned HIB_WAKE_CYCLES = lpsq_pkg::HIB_WAKE_CYC,
    parameter longint unsigned SHD_WAKE_CYCLES = lpsq_pkg::SHD_WAKE_CYC,
    parameter longint unsigned RESTORE_CYCLES = lpsq_pkg::RESTORE_CYC,
    parameter int unsigned IDLE_CYCLES = 1_000
) (
    // Clock, reset and enable
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic clk_en_i,
    // Host pins, asynchronous
    input wire logic hibernate_wake_request_n_i,
    input wire logic external_reset_low_i,
    input wire logic [2:0] boot_option_straps_i,
    // Internal activity and requests, same clock
    input wire logic activity_i,
    input wire logic host_cmd_i,
    input wire logic wake_timer_i,
    input wire logic hib_req_i,
    input wire logic shd_req_i,
    input wire lpsq_pkg::lpsq_restore_t restore_sel_i,
    input wire logic restore_pending_i,
    input wire logic flash_prot_access_i,
    // Status and power control
    output lpsq_pkg::lpsq_state_t state_o,
    output lpsq_pkg::lpsq_pwr_t pwr_o,
    output lpsq_pkg::lpsq_restore_t restore_mode_o,
    output logic restore_pending_o,
    output logic flash_prot_deny_o
);
    import lpsq_pkg::*;

    if (SHD_WAKE_CYCLES >= (64'h1 << CNT_W) || RESTORE_CYCLES >= (64'h1 << CNT_W) ||
        HIB_WAKE_CYCLES >= (64'h1 << CNT_W) || RET_WAKE_CYCLES == 0 ||
        IDLE_CYCLES == 0 || IDLE_CYCLES >= (1 << CNT_W)) begin : g_bad_counts
        $error("lpsq_top: cycle counts out of counter range");
    end

    localparam logic [CNT_W-1:0] RET_N = CNT_W'(RET_WAKE_CYCLES - 1);
    localparam logic [CNT_W-1:0] HIB_N = CNT_W'(HIB_WAKE_CYCLES);
    localparam logic [CNT_W-1:0] SHD_N = CNT_W'(SHD_WAKE_CYCLES);
    localparam logic [CNT_W-1:0] RES_N = CNT_W'(RESTORE_CYCLES);
    localparam logic [CNT_W-1:0] IDLE_N = CNT_W'(IDLE_CYCLES);

    logic hib_wake_n_s;
    logic ext_rst_n_s;
    logic [2:0] straps_s;
    logic ext_rst_n_q;
    logic ext_rst_rise;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] idle_q;
    logic waking_q;
    lpsq_state_t state_q;
    lpsq_state_t state_d;
    logic [CNT_W-1:0] cnt_d;
    lpsq_restore_t mode_q;

    lpsq_sync #(
        .WIDTH(5),
        .RST_VAL(5'h1f)
    ) u_pin_sync (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .clk_en_i(clk_en_i),
        .async_i({hibernate_wake_request_n_i, external_reset_low_i, boot_option_straps_i}),
        .sync_o({hib_wake_n_s, ext_rst_n_s, straps_s})
    );

    // Edge detection reads only the synchronised copy.
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            ext_rst_n_q <= 1'b1;
        end else if (clk_en_i) begin
            ext_rst_n_q <= ext_rst_n_s;
        end
    end
    assign ext_rst_rise = ext_rst_n_s & ~ext_rst_n_q;

    // Inactivity timer; any activity or command keeps the device out of sleep.
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            idle_q <= CNT_ZERO;
        end else if (clk_en_i) begin
            if (state_q != LPSQ_ACTIVE || activity_i || host_cmd_i) begin
                idle_q <= CNT_ZERO;
            end else if (idle_q != IDLE_N) begin
                idle_q <= idle_q + CNT_ONE;
            end
        end
    end

    always_comb begin
        state_d = state_q;
        cnt_d = (cnt_q != CNT_ZERO) ? cnt_q - CNT_ONE : CNT_ZERO;
        unique case (state_q)
            LPSQ_ACTIVE: begin
                if (shd_req_i) begin
                    state_d = LPSQ_SHUTDN;
                end else if (hib_req_i) begin
                    state_d = LPSQ_HIBER;
                end else if (idle_q == IDLE_N) begin
                    state_d = LPSQ_RETAIN; // RULE_01
                end
            end
            LPSQ_RETAIN: begin
                // Wake is fast since state was kept; count stays inside the bound.
                if (waking_q) begin
                    if (cnt_q == CNT_ZERO) begin
                        state_d = LPSQ_ACTIVE; // RULE_02 RULE_03
                    end
                end else if (host_cmd_i || wake_timer_i) begin
                    cnt_d = RET_N; // RULE_01 RULE_02
                end
            end
            LPSQ_HIBER: begin
                if (!hib_wake_n_s) begin
                    state_d = LPSQ_BOOT; // RULE_05
                    cnt_d = HIB_N; // RULE_06
                end
            end
            LPSQ_SHUTDN: begin
                // Only a fresh external reset release brings the device back.
                if (ext_rst_rise) begin
                    state_d = LPSQ_BOOT;
                    cnt_d = SHD_N; // RULE_07
                end
            end
            LPSQ_BOOT: begin
                // A restore cut short by power loss is taken up again before normal boot.
                if (restore_pending_o || restore_pending_i) begin
                    state_d = LPSQ_RESTORE; // RULE_10
                    cnt_d = RES_N;
                end else if (cnt_q == CNT_ZERO) begin
                    state_d = LPSQ_ACTIVE; // RULE_13
                end
            end
            LPSQ_RESTORE: begin
                if (cnt_q == CNT_ZERO) begin
                    state_d = LPSQ_ACTIVE; // RULE_11
                end
            end
            default: begin
                state_d = LPSQ_BOOT;
                cnt_d = SHD_N;
            end
        endcase
        // External reset release overrides everything; straps pick restore or boot.
        if (ext_rst_rise) begin
            if (straps_s == STRAP_RESTORE) begin // RULE_09
                state_d = LPSQ_RESTORE;
                cnt_d = RES_N; // RULE_11
            end else if (state_q != LPSQ_SHUTDN) begin
                state_d = LPSQ_BOOT;
                cnt_d = SHD_N;
            end
        end
    end

    // The resume decision lives in state_d so state_o and pwr_o never disagree with it; restore_mode_o follows mode_q one cycle later.
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_q <= LPSQ_BOOT;
            cnt_q <= CNT_ZERO;
            waking_q <= 1'b0;
        end else if (clk_en_i) begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            waking_q <= (state_q == LPSQ_RETAIN) && state_d == LPSQ_RETAIN &&
                        (waking_q || host_cmd_i || wake_timer_i);
        end
    end

    // The pending flag is mirrored out so always-on storage can keep it across power loss.
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            mode_q <= LPSQ_RST_NONE;
            restore_pending_o <= 1'b0;
        end else if (clk_en_i) begin
            if (ext_rst_rise && straps_s == STRAP_RESTORE) begin
                mode_q <= (restore_sel_i == LPSQ_RST_FULL) ? LPSQ_RST_FULL :
                          (restore_sel_i == LPSQ_RST_PARAMS) ? LPSQ_RST_PARAMS :
                          LPSQ_RST_NONE; // RULE_08
                restore_pending_o <= 1'b1; // RULE_10
            end else if (state_q == LPSQ_RESTORE && cnt_q == CNT_ZERO) begin
                restore_pending_o <= 1'b0;
            end else if (restore_pending_i && state_q == LPSQ_BOOT) begin
                // Only boot listens, so the store's lagging copy cannot re-arm a finished restore.
                restore_pending_o <= 1'b1; // RULE_10
                if (mode_q == LPSQ_RST_NONE) begin
                    mode_q <= (restore_sel_i == LPSQ_RST_FULL ||
                               restore_sel_i == LPSQ_RST_PARAMS) ? restore_sel_i :
                              LPSQ_RST_NONE; // RULE_08
                end
            end
        end
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_o <= LPSQ_BOOT;
            pwr_o <= '0;
            restore_mode_o <= LPSQ_RST_NONE;
            flash_prot_deny_o <= 1'b0;
        end else if (clk_en_i) begin
            state_o <= state_d;
            pwr_o.core_pwr_on <= state_d != LPSQ_HIBER && state_d != LPSQ_SHUTDN; // RULE_04
            pwr_o.rtc_on <= state_d != LPSQ_SHUTDN; // RULE_04 RULE_07
            pwr_o.retain_en <= state_d == LPSQ_RETAIN; // RULE_03
            pwr_o.ready <= state_d == LPSQ_ACTIVE; // RULE_13 RULE_11
            pwr_o.restoring <= state_d == LPSQ_RESTORE;
            restore_mode_o <= mode_q;
            flash_prot_deny_o <= flash_prot_access_i; // RULE_12
        end
    end
endmodule // lpsq_top

// >>> verification/lpsq_properties.sv
// Checker on the sequencer's top ports: power levels per state, wake and restore timing.
// Assumes it is bound to lpsq_top with the same short wake counts as the bench.
`timescale 1ns/1ps
module lpsq_checker
    import lpsq_pkg::*;
#(
    parameter longint unsigned RET_WAKE_CYCLES = 4,
    parameter longint unsigned HIB_WAKE_CYCLES = 10
) (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic clk_en_i,
    input wire logic hibernate_wake_request_n_i,
    input wire logic external_reset_low_i,
    input wire logic [2:0] boot_option_straps_i,
    input wire logic host_cmd_i,
    input wire logic wake_timer_i,
    input wire logic flash_prot_access_i,
    input wire lpsq_pkg::lpsq_state_t state_o,
    input wire lpsq_pkg::lpsq_pwr_t pwr_o,
    input wire logic restore_pending_o,
    input wire logic flash_prot_deny_o
);
    localparam int RET_MAX = int'(RET_WAKE_CYCLES) + 4;
    localparam int HIB_MAX = int'(HIB_WAKE_CYCLES) + 4;
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    deny_follow_a: assert property (!$past(rst_i) && $past(clk_en_i)
        |-> flash_prot_deny_o == $past(flash_prot_access_i))
        else $error("deny does not follow access");
    retain_keep_a: assert property (state_o == LPSQ_RETAIN |-> pwr_o.retain_en)
        else $error("retention off in sleep");
    retain_wake_a: assert property (state_o == LPSQ_RETAIN && (host_cmd_i || wake_timer_i)
        |-> ##[1:RET_MAX] state_o == LPSQ_ACTIVE) else $error("sleep wake too slow");
    hiber_power_a: assert property (state_o == LPSQ_HIBER
        |-> !pwr_o.core_pwr_on && pwr_o.rtc_on) else $error("hibernate power wrong");
    shut_power_a: assert property (state_o == LPSQ_SHUTDN
        |-> !pwr_o.core_pwr_on && !pwr_o.rtc_on) else $error("shutdown power wrong");
    hiber_wake_a: assert property (state_o == LPSQ_HIBER && !hibernate_wake_request_n_i
        |-> ##[1:5] state_o == LPSQ_BOOT) else $error("wake pin ignored");
    boot_run_a: assert property ($past(state_o) == LPSQ_HIBER && state_o == LPSQ_BOOT
        |-> !pwr_o.ready [*8] ##[1:HIB_MAX] state_o == LPSQ_ACTIVE) else $error("boot span wrong");
    busy_ready_a: assert property (state_o inside {LPSQ_BOOT, LPSQ_RESTORE}
        |-> !pwr_o.ready) else $error("ready while busy");
    restore_go_a: assert property ($rose(external_reset_low_i)
        && boot_option_straps_i == STRAP_RESTORE |-> ##[1:6] state_o == LPSQ_RESTORE
        && restore_pending_o) else $error("restore not started");
endmodule // lpsq_checker

// >>> verification/lpsq_host_model.sv
// Host model: drives the wake line, the boot straps and the external reset.
// Assumes the bench calls its tasks; pins change on the falling clock edge.
`timescale 1ns/1ps
module lpsq_host_model (
    // Clock
    input wire logic core_clk_i,
    // Host pins
    output logic hibernate_wake_request_n_o,
    output logic external_reset_low_o,
    output logic [2:0] boot_option_straps_o
);
    initial begin
        hibernate_wake_request_n_o = 1'b1;
        external_reset_low_o = 1'b1;
        boot_option_straps_o = 3'h0;
    end
    // The wake line is a level, held until the device is up again.
    task automatic set_wake(input logic req);
        @(negedge core_clk_i);
        hibernate_wake_request_n_o <= !req;
    endtask
    // Straps settle before the rise and stay a while, since the pins pass synchronisers.
    task automatic reset_with(input logic [2:0] straps);
        @(negedge core_clk_i);
        boot_option_straps_o <= straps;
        external_reset_low_o <= 1'b0;
        repeat (3) @(negedge core_clk_i);
        external_reset_low_o <= 1'b1;
        repeat (8) @(negedge core_clk_i);
        boot_option_straps_o <= 3'h0;
    endtask
endmodule // lpsq_host_model

// >>> verification/lpsq_top_tb.sv
// Bench for the sequencer: sleep, hibernate, shutdown, restore and power loss.
// Assumes the host model drives the pins and a small store keeps the restore flag.
`timescale 1ns/1ps
module lpsq_top_tb;
    import lpsq_pkg::*;
    logic core_clk_i = 1'b0;
    logic rst_i, clk_en;
    logic activity, host_cmd, wake_tmr, acc;
    logic hib_req, shd_req, pend_store = 1'b0, pend_prev;
    logic wake_n, ext_rst, pend_o, deny;
    logic [2:0] straps;
    lpsq_restore_t sel;
    lpsq_restore_t mode;
    lpsq_state_t state, prev_st;
    lpsq_pwr_t pwr;
    lpsq_state_t exp_q[$];
    int mismatches = 0;
    int n_tests = 0;
    always #20 core_clk_i = ~core_clk_i;
    lpsq_top #(.RET_WAKE_CYCLES(4), .HIB_WAKE_CYCLES(10), .SHD_WAKE_CYCLES(20),
        .RESTORE_CYCLES(30), .IDLE_CYCLES(8)) dut (.core_clk_i(core_clk_i), .rst_i(rst_i),
        .clk_en_i(clk_en), .hibernate_wake_request_n_i(wake_n), .external_reset_low_i(ext_rst),
        .boot_option_straps_i(straps), .activity_i(activity), .host_cmd_i(host_cmd),
        .wake_timer_i(wake_tmr), .hib_req_i(hib_req), .shd_req_i(shd_req),
        .restore_sel_i(sel), .restore_pending_i(pend_store), .flash_prot_access_i(acc),
        .state_o(state), .pwr_o(pwr), .restore_mode_o(mode), .restore_pending_o(pend_o),
        .flash_prot_deny_o(deny));
    lpsq_host_model host (.core_clk_i(core_clk_i), .hibernate_wake_request_n_o(wake_n),
        .external_reset_low_o(ext_rst), .boot_option_straps_o(straps));
    // Always-on store: a core reset must not wipe the flag.
    always @(posedge core_clk_i) begin
        if (rst_i) pend_prev <= 1'b0;
        else begin
            if (pend_o != pend_prev) pend_store <= pend_o;
            pend_prev <= pend_o;
        end
    end
    always @(negedge core_clk_i) acc <= 1'($urandom_range(0, 1));
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // A pass through BOOT is judged only when expected; a restore may or may not reboot.
    always @(posedge core_clk_i) begin
        if (rst_i) prev_st <= LPSQ_BOOT;
        else if (state !== prev_st) begin
            prev_st <= state;
            if (exp_q.size() == 0) check(8'(state), 8'hff);
            else if (state !== LPSQ_BOOT || exp_q[0] === LPSQ_BOOT) begin
                check(8'(state), 8'(exp_q.pop_front()));
            end
        end
    end
    task automatic wait_st(input lpsq_state_t s);
        int n;
        n = 0;
        while (state !== s && n < 500) begin
            @(negedge core_clk_i);
            n++;
        end
        check(8'(state), 8'(s));
    endtask
    task automatic summarize();
        $display("tests %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge core_clk_i);
        mismatches++;
        summarize();
    end
    initial begin
        void'($urandom(32'h4b7b3307));
        rst_i = 1'b1;
        clk_en = 1'b1;
        {activity, host_cmd, wake_tmr} = 3'b100;
        {hib_req, shd_req} = 2'b00;
        sel = LPSQ_RST_NONE;
        repeat (3) @(negedge core_clk_i);
        rst_i = 1'b0;
        exp_q.push_back(LPSQ_ACTIVE);
        wait_st(LPSQ_ACTIVE);
        for (int i = 0; i < 2; i++) begin
            exp_q.push_back(LPSQ_RETAIN);
            exp_q.push_back(LPSQ_ACTIVE);
            activity = 1'b0;
            // A frozen clock enable must keep the idle count from running out.
            if (i == 0) begin
                clk_en = 1'b0;
                repeat (10 + $urandom_range(0, 5)) @(negedge core_clk_i);
                check(8'(state), 8'(LPSQ_ACTIVE));
                clk_en = 1'b1;
            end
            wait_st(LPSQ_RETAIN);
            check(8'(pwr.retain_en), 8'h01);
            repeat ($urandom_range(0, 3)) @(negedge core_clk_i);
            if (i == 0) host_cmd = 1'b1;
            else wake_tmr = 1'b1;
            activity = 1'b1;
            @(negedge core_clk_i);
            {host_cmd, wake_tmr} = 2'b00;
            wait_st(LPSQ_ACTIVE);
        end
        exp_q.push_back(LPSQ_HIBER);
        exp_q.push_back(LPSQ_BOOT);
        exp_q.push_back(LPSQ_ACTIVE);
        hib_req = 1'b1;
        @(negedge core_clk_i);
        hib_req = 1'b0;
        wait_st(LPSQ_HIBER);
        check(8'({pwr.core_pwr_on, pwr.rtc_on}), 8'h01);
        host.set_wake(1'b1);
        wait_st(LPSQ_ACTIVE);
        host.set_wake(1'b0);
        exp_q.push_back(LPSQ_SHUTDN);
        {hib_req, shd_req} = 2'b11;
        @(negedge core_clk_i);
        {hib_req, shd_req} = 2'b00;
        wait_st(LPSQ_SHUTDN);
        check(8'({pwr.core_pwr_on, pwr.rtc_on}), 8'h00);
        host.set_wake(1'b1);
        repeat (10) @(negedge core_clk_i);
        check(8'(state), 8'(LPSQ_SHUTDN));
        host.set_wake(1'b0);
        exp_q.push_back(LPSQ_BOOT);
        exp_q.push_back(LPSQ_ACTIVE);
        host.reset_with(3'h0);
        wait_st(LPSQ_ACTIVE);
        for (int i = 0; i < 4; i++) begin
            sel = lpsq_restore_t'(i);
            exp_q.push_back(LPSQ_RESTORE);
            exp_q.push_back(LPSQ_ACTIVE);
            host.reset_with(STRAP_RESTORE);
            wait_st(LPSQ_RESTORE);
            check(8'(mode), (i == 3) ? 8'h00 : 8'(i));
            check(8'(pend_o), 8'h01);
            wait_st(LPSQ_ACTIVE);
        end
        exp_q.push_back(LPSQ_RESTORE);
        host.reset_with(STRAP_RESTORE);
        wait_st(LPSQ_RESTORE);
        rst_i = 1'b1;
        repeat (3) @(negedge core_clk_i);
        rst_i = 1'b0;
        exp_q.push_back(LPSQ_RESTORE);
        exp_q.push_back(LPSQ_ACTIVE);
        wait_st(LPSQ_RESTORE);
        wait_st(LPSQ_ACTIVE);
        check(8'(pend_o), 8'h00);
        @(negedge core_clk_i);
        check(8'(pend_store), 8'h00);
        summarize();
    end
endmodule // lpsq_top_tb
bind lpsq_top lpsq_checker #(.RET_WAKE_CYCLES(RET_WAKE_CYCLES),
    .HIB_WAKE_CYCLES(HIB_WAKE_CYCLES)) u_chk (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .hibernate_wake_request_n_i(hibernate_wake_request_n_i),
    .external_reset_low_i(external_reset_low_i), .boot_option_straps_i(boot_option_straps_i),
    .clk_en_i(clk_en_i), .host_cmd_i(host_cmd_i), .wake_timer_i(wake_timer_i),
    .flash_prot_access_i(flash_prot_access_i), .state_o(state_o), .pwr_o(pwr_o),
    .restore_pending_o(restore_pending_o), .flash_prot_deny_o(flash_prot_deny_o));
